// *** logic/mic_pkg.sv ***
// Constants, field positions and types of the maskable interrupt control.
// Assumes a single CPU clock domain and an 8-bit register port.
`default_nettype none

package mic_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] INFO_ADDR = 8'h00;
  localparam logic [7:0] INFO_LVL_ADDR = 8'h01;
  localparam logic [7:0] CTRL_BASE = 8'h50;
  localparam logic [7:0] TA0_CTRL_ADDR = 8'h55;
  localparam logic [7:0] PSW_ADDR = 8'h60;
  localparam logic [7:0] STAT_ADDR = 8'h61;

  // ----------------------------------------------------------------
  // Field positions, write mask, reset values and source number base
  // ----------------------------------------------------------------
  localparam int LVL_LSB = 0;
  localparam int REQ_BIT = 3;
  localparam int PSW_I_BIT = 0;
  localparam int PSW_D_BIT = 1;
  localparam int PSW_U_BIT = 2;
  localparam int IPL_LSB = 4;
  localparam logic [7:0] PSW_MASK = 8'h77;
  localparam logic [2:0] LVL_RST = 3'h0;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [5:0] SRC_NUM_BASE = 6'h10;

  // ----------------------------------------------------------------
  // Sequence timing, in CPU cycles, and the lowest trap number that keeps U
  // ----------------------------------------------------------------
  localparam logic [4:0] SEQ_BASE_CYC = 5'h12;
  localparam logic [4:0] SEQ_BUS8_CYC = 5'h14;
  localparam logic [4:0] DBG_EXTRA_CYC = 5'h02;
  localparam logic [4:0] STEP_EXTRA_CYC = 5'h01;
  localparam logic [4:0] STEP_CLRF = 5'h01;
  localparam logic [4:0] STEP_PSHF = 5'h02;
  localparam logic [4:0] STEP_PSHPC = 5'h03;
  localparam logic [5:0] MAX_INSTR_WAIT = 6'h1e;
  localparam logic [5:0] TRAP_U_LO = 6'h20;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TRAP_SOFT, TRAP_STEP, TRAP_DBG} mic_trap_t;
  typedef enum logic {ST_IDLE, ST_SEQ} mic_state_t;

endpackage

`default_nettype wire

// *** logic/mic_ctrl.sv ***
// Maskable interrupt acceptance and interrupt sequence of the CPU.
// Assumes peripherals and core share clk; request events are one-cycle
// pulses, instruction boundaries come from the core.
`default_nettype none

module mic_ctrl
  import mic_pkg::*;
#(
  parameter int N_SRC = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [N_SRC-1:0] src_evt,
  input wire logic instr_done,
  input wire logic instr_susp,
  input wire logic trap_req,
  input wire logic [1:0] trap_kind,
  input wire logic [5:0] trap_num,
  input wire logic vec_odd,
  input wire logic sp_odd,
  input wire logic bus8,
  input wire logic [19:0] pc_in,
  output logic seq_active,
  output logic int_ack,
  output logic [5:0] int_num,
  output logic [2:0] int_lvl,
  output logic stack_push,
  output logic [19:0] stack_data,
  output logic resume,
  output logic [7:0] psw
);
  localparam int IDX_W = (N_SRC > 1) ? $clog2(N_SRC) : 1;
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mic_state_t st_q;
  logic [4:0] cnt_q;
  logic [4:0] len_q;
  logic [2:0] lvl_q [N_SRC];
  logic [N_SRC-1:0] req_q;
  logic [7:0] psw_q;
  logic [7:0] temp_q;
  logic trap_q;
  logic keep_u_q;
  logic [IDX_W-1:0] idx_q;
  logic [5:0] num_q;
  logic [2:0] acc_lvl_q;
  logic [5:0] wait_q;
  logic late_q;
  logic ack_q;
  logic push_q;
  logic [19:0] sdata_q;
  logic resume_q;
  logic [7:0] rdata_q;
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [7:0] ctrl_off;
  logic ctrl_hit;
  logic [IDX_W-1:0] ctrl_idx;
  logic [2:0] cpu_priority_threshold;
  logic info_rd;
  assign ctrl_off = reg_addr - CTRL_BASE;
  assign ctrl_hit = ctrl_off < 8'(N_SRC);
  assign ctrl_idx = IDX_W'(ctrl_off);
  assign cpu_priority_threshold = psw_q[IPL_LSB +: 3];
  assign info_rd = reg_rd && reg_addr == INFO_ADDR;
  // ----------------------------------------------------------------
  // Priority judge
  // ----------------------------------------------------------------
  logic win_ok;
  logic [IDX_W-1:0] win_idx;
  logic [2:0] win_lvl;
  // Ascending scan with strict compare keeps the lowest index on ties
  always_comb begin
    win_ok = 1'b0;
    win_idx = '0;
    win_lvl = '0;
    for (int i = 0; i < N_SRC; i++) begin
      if (req_q[i] && lvl_q[i] > cpu_priority_threshold && (!win_ok || lvl_q[i] > win_lvl)) begin
        win_ok = 1'b1;
        win_idx = IDX_W'(i);
        win_lvl = lvl_q[i];
      end
    end
  end
  logic acc_ok;
  logic sel_trap;
  logic start;
  logic trap_dbg;
  logic trap_step;
  assign acc_ok = win_ok && psw_q[PSW_I_BIT];
  assign trap_dbg = trap_kind == 2'(TRAP_DBG);
  assign trap_step = trap_kind == 2'(TRAP_STEP);
  // Debugger break and trap instructions outrank peripherals; step does not
  assign sel_trap = trap_req && instr_done && (!trap_step || !acc_ok);
  // String and repeat instructions yield mid-way via instr_susp
  assign start = st_q == ST_IDLE && (sel_trap || (acc_ok && (instr_done || instr_susp)));
  // Sequence length from bus width, parity and kind
  logic [4:0] len_d;
  always_comb begin
    len_d = bus8 ? SEQ_BUS8_CYC : SEQ_BASE_CYC + 5'(vec_odd) + 5'(sp_odd);
    if (sel_trap && trap_dbg) begin
      len_d = len_d + DBG_EXTRA_CYC;
    end else if (sel_trap && trap_step) begin
      len_d = len_d + STEP_EXTRA_CYC;
    end
  end
  logic seq_last;
  assign seq_last = st_q == ST_SEQ && cnt_q == len_q - 5'h01;
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Acceptance details are frozen at the start edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      len_q <= '0;
      trap_q <= 1'b0;
      keep_u_q <= 1'b0;
      idx_q <= '0;
      num_q <= '0;
      acc_lvl_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (start) begin
            st_q <= ST_SEQ;
            len_q <= len_d;
            trap_q <= sel_trap;
            keep_u_q <= sel_trap && !trap_step && !trap_dbg && trap_num >= TRAP_U_LO;
            idx_q <= win_idx;
            // Internal read of the info location: number and level
            num_q <= sel_trap ? trap_num : SRC_NUM_BASE + 6'(win_idx);
            acc_lvl_q <= sel_trap ? cpu_priority_threshold : win_lvl;
          end
        end
        ST_SEQ: begin
          cnt_q <= cnt_q + 5'h01;
          if (seq_last) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Level fields written only by software
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < N_SRC; i++) begin
        lvl_q[i] <= LVL_RST;
      end
    end else if (reg_wr && ctrl_hit) begin
      lvl_q[ctrl_idx] <= reg_wdata[LVL_LSB +: 3];
    end
  end
  // Request bits: event set beats every clear, so read-modify-write is safe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= '0;
    end else begin
      for (int i = 0; i < N_SRC; i++) begin
        if (src_evt[i]) begin
          req_q[i] <= 1'b1;
        end else if (st_q == ST_SEQ && cnt_q == 5'h00 && !trap_q && idx_q == IDX_W'(i)) begin
          req_q[i] <= 1'b0;
        end else if (info_rd && st_q == ST_IDLE && win_ok && win_idx == IDX_W'(i)) begin
          req_q[i] <= 1'b0;
        end else if (reg_wr && ctrl_hit && ctrl_idx == IDX_W'(i) && !reg_wdata[REQ_BIT]) begin
          req_q[i] <= 1'b0;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Status word and temporary copy
  // ----------------------------------------------------------------
  // Software writes are held off while the sequence owns the flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      psw_q <= PSW_RST;
    end else if (st_q == ST_SEQ && cnt_q == STEP_CLRF) begin
      psw_q[PSW_I_BIT] <= 1'b0;
      psw_q[PSW_D_BIT] <= 1'b0;
      if (!keep_u_q) begin
        psw_q[PSW_U_BIT] <= 1'b0;
      end
    end else if (seq_last && !trap_q) begin
      psw_q[IPL_LSB +: 3] <= acc_lvl_q;
    end else if (reg_wr && reg_addr == PSW_ADDR && st_q == ST_IDLE) begin
      psw_q <= reg_wdata & PSW_MASK;
    end
  end
  // Hidden copy of the status word from before the sequence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_q <= PSW_RST;
    end else if (start) begin
      temp_q <= psw_q;
    end
  end
  // ----------------------------------------------------------------
  // Core-facing strobes
  // ----------------------------------------------------------------
  // Flags word first, then the program counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      push_q <= 1'b0;
      sdata_q <= '0;
      resume_q <= 1'b0;
    end else begin
      ack_q <= start;
      push_q <= st_q == ST_SEQ && (cnt_q == STEP_PSHF || cnt_q == STEP_PSHPC);
      if (st_q == ST_SEQ && cnt_q == STEP_PSHF) begin
        sdata_q <= {pc_in[19:16], 8'h00, temp_q};
      end else if (st_q == ST_SEQ && cnt_q == STEP_PSHPC) begin
        sdata_q <= pc_in;
      end
      resume_q <= seq_last;
    end
  end
  // ----------------------------------------------------------------
  // Boundary wait monitor
  // ----------------------------------------------------------------
  // Flags a core whose instruction runs past the worst case
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= '0;
      late_q <= 1'b0;
    end else begin
      if (acc_ok && st_q == ST_IDLE && !start) begin
        wait_q <= (wait_q == 6'h3f) ? wait_q : wait_q + 6'h01;
      end else begin
        wait_q <= '0;
      end
      if (wait_q > MAX_INSTR_WAIT) begin
        late_q <= 1'b1;
      end else if (reg_wr && reg_addr == STAT_ADDR) begin
        late_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      if (ctrl_hit) begin
        rdata_q <= {4'h0, req_q[ctrl_idx], lvl_q[ctrl_idx]};
      end else if (reg_addr == INFO_ADDR) begin
        rdata_q <= win_ok ? {2'b00, SRC_NUM_BASE + 6'(win_idx)} : 8'h00;
      end else if (reg_addr == INFO_LVL_ADDR) begin
        rdata_q <= {5'h00, win_ok ? win_lvl : 3'h0};
      end else if (reg_addr == PSW_ADDR) begin
        rdata_q <= psw_q;
      end else if (reg_addr == STAT_ADDR) begin
        rdata_q <= {6'h00, late_q, st_q == ST_SEQ};
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign seq_active = st_q == ST_SEQ;
  assign int_ack = ack_q;
  assign int_num = num_q;
  assign int_lvl = acc_lvl_q;
  assign stack_push = push_q;
  assign stack_data = sdata_q;
  assign resume = resume_q;
  assign psw = psw_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [4:0] run_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= '0;
    end else begin
      run_q <= (st_q == ST_SEQ) ? run_q + 5'h01 : 5'h00;
    end
  end

  a_reset_flag_clear: assert property ($rose(rst_b) |-> !psw_q[PSW_I_BIT])
    else $error("enable flag set after reset");
  a_accept_needs_flag: assert property (int_ack && !trap_q |-> $past(psw_q[PSW_I_BIT]))
    else $error("maskable accepted with enable flag clear");
  a_level_above_ipl: assert property (int_ack && !trap_q |-> acc_lvl_q > $past(cpu_priority_threshold))
    else $error("accepted level not above threshold");
  a_request_set: assert property (src_evt != '0 |=> (req_q & $past(src_evt)) == $past(src_evt))
    else $error("request event lost");
  a_sw_clear: assert property (reg_wr && ctrl_hit && !reg_wdata[REQ_BIT] && src_evt == '0
      && st_q == ST_IDLE |=> !req_q[$past(ctrl_idx)])
    else $error("software clear ignored");
  a_hw_clear_req: assert property (int_ack && !trap_q && src_evt == '0 |=> !req_q[idx_q])
    else $error("request not cleared by sequence");
  a_start_next: assert property (st_q == ST_IDLE && acc_ok && instr_done |=> int_ack)
    else $error("sequence did not start after boundary");
  a_temp_copy: assert property (int_ack |-> temp_q == $past(psw_q))
    else $error("temporary copy mismatch");
  a_seq_length: assert property (resume_q |-> $past(run_q) + 5'h01 == len_q)
    else $error("sequence length wrong");
  a_flags_cleared: assert property (resume_q |-> !psw_q[PSW_I_BIT] && !psw_q[PSW_D_BIT])
    else $error("flags not cleared by sequence");
  a_ipl_loaded: assert property (resume_q && !trap_q |-> cpu_priority_threshold == acc_lvl_q)
    else $error("threshold not loaded");
  a_push_order: assert property (int_ack ##3 stack_push |-> stack_data[7:0] == temp_q ##1 stack_push)
    else $error("push order wrong");
  a_ctrl_indep: assert property (reg_wr && ctrl_hit && st_q == ST_IDLE && !start |=> $stable(psw_q))
    else $error("control write disturbed status word");

  c_maskable_seq: cover property (int_ack && !trap_q ##[1:30] resume_q);
  c_dbg_break: cover property (start && sel_trap && trap_dbg);
  c_bus8_seq: cover property (resume_q && len_q == SEQ_BUS8_CYC);
  c_suspend: cover property (start && instr_susp && !instr_done);

endmodule // mic_ctrl

`default_nettype wire

// *** dv/mic_core_model.sv ***
// Behavioural CPU core that sits beside the interrupt control.
// Assumes one clock; the core stalls while the sequence runs.
`default_nettype none

module mic_core_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic seq_active,
  input wire logic trap_cmd,
  input wire logic [1:0] cmd_kind,
  input wire logic [5:0] cmd_num,
  input wire logic [7:0] gap,
  output logic instr_done,
  output logic trap_req,
  output logic [1:0] trap_kind,
  output logic [5:0] trap_num,
  output logic [19:0] pc_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Instruction stream
  // ----------------------------------------------------------------
  logic [7:0] cnt_q;
  logic pend_q;

  // Trap identity is held by the bench for the whole request
  assign trap_kind = cmd_kind;
  assign trap_num = cmd_num;

  // Boundary every gap+1 cycles; a large gap models a slow instruction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      pend_q <= 1'b0;
      instr_done <= 1'b0;
      trap_req <= 1'b0;
      pc_in <= 20'h1_2340;
    end else begin
      instr_done <= 1'b0;
      trap_req <= 1'b0;
      if (trap_cmd) begin
        pend_q <= 1'b1;
      end
      if (!seq_active && cnt_q >= gap) begin
        cnt_q <= 8'h00;
        instr_done <= 1'b1;
        pc_in <= pc_in + 20'h0_0002;
        // Trap only rides on a boundary, as the core would issue it
        if (pend_q || trap_cmd) begin
          trap_req <= 1'b1;
          pend_q <= 1'b0;
        end
      end else if (!seq_active) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule // mic_core_model

`default_nettype wire

// *** dv/tb_maskable_interrupt_control.sv ***
// Self-checking bench for the maskable interrupt control.
// Assumes mic_pkg compiled first and the core model beside the block.
`default_nettype none

module tb_maskable_interrupt_control;
  import mic_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] src_evt = 8'h00;
  logic instr_susp = 1'b0;
  logic vec_odd = 1'b0;
  logic sp_odd = 1'b0;
  logic bus8 = 1'b0;
  logic trap_cmd = 1'b0;
  logic [1:0] cmd_kind = 2'h0;
  logic [5:0] cmd_num = 6'h00;
  logic [7:0] gap = 8'h04;
  logic [7:0] reg_rdata, psw;
  logic instr_done, trap_req, seq_active, int_ack, stack_push, resume;
  logic [1:0] trap_kind;
  logic [5:0] trap_num, int_num;
  logic [2:0] int_lvl;
  logic [19:0] pc_in, stack_data;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int done_cyc = 0;
  int wt;

  mic_ctrl #(.N_SRC(8)) dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_evt(src_evt), .instr_done(instr_done),
    .instr_susp(instr_susp), .trap_req(trap_req), .trap_kind(trap_kind), .trap_num(trap_num),
    .vec_odd(vec_odd), .sp_odd(sp_odd), .bus8(bus8), .pc_in(pc_in), .seq_active(seq_active),
    .int_ack(int_ack), .int_num(int_num), .int_lvl(int_lvl), .stack_push(stack_push),
    .stack_data(stack_data), .resume(resume), .psw(psw));

  mic_core_model core_u (.clk(clk), .rst_b(rst_b), .seq_active(seq_active), .trap_cmd(trap_cmd),
    .cmd_kind(cmd_kind), .cmd_num(cmd_num), .gap(gap), .instr_done(instr_done), .trap_req(trap_req),
    .trap_kind(trap_kind), .trap_num(trap_num), .pc_in(pc_in));

  // ----------------------------------------------------------------
  // Clock, cycle count and common tasks
  // ----------------------------------------------------------------
  always #5 clk = ~clk;

  // Edge index of the last instruction boundary seen by the block
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (instr_done === 1'b1) begin
      done_cyc <= cyc + 1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, exp);
  endtask

  task automatic evt(input logic [7:0] m);
    @(posedge clk);
    src_evt <= m;
    @(posedge clk);
    src_evt <= 8'h00;
  endtask

  task automatic noack(input int c);
    repeat (c) begin
      @(posedge clk);
      #1 chk("int_ack idle", int_ack, 1'b0);
    end
  endtask

  // Follow one whole sequence: acceptance, pushes, length, final word
  task automatic seq(input logic [5:0] num, input logic [2:0] lvl, input int len,
                     input logic [7:0] p0, input logic [7:0] p1, output int w);
    int n, t0, np;
    logic [19:0] w0, w1, pc;
    n = 0;
    np = 0;
    w0 = 20'h0_0000;
    w1 = 20'h0_0000;
    #1;
    while (int_ack !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    w = n;
    t0 = cyc;
    pc = pc_in;
    chk("int_ack", int_ack, 1'b1);
    chk("int_num", int_num, num);
    chk("int_lvl", int_lvl, lvl);
    chk("seq_active", seq_active, 1'b1);
    if (instr_susp !== 1'b1) chk("boundary", cyc - done_cyc, 0);
    while (resume !== 1'b1 && n < 200) begin
      if (stack_push === 1'b1) begin
        if (np == 0) w0 = stack_data;
        else w1 = stack_data;
        np++;
      end
      @(posedge clk);
      #1 n++;
    end
    chk("seq_len", cyc - t0, len);
    chk("push_count", np, 2);
    chk("push_flags", w0, {pc[19:16], 8'h00, p0});
    chk("push_pc", w1, pc);
    chk("psw_after", psw, p1);
    chk("seq_done", seq_active, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_gate();
    rd(PSW_ADDR, 8'h00, "psw_reset");
    rd(8'h70, 8'h00, "unmapped");
    wr(TA0_CTRL_ADDR, 8'h03);
    evt(8'h20);
    rd(TA0_CTRL_ADDR, 8'h0b, "req_set");
    noack(40);
    wr(PSW_ADDR, 8'h31);
    noack(40);
    wr(PSW_ADDR, 8'h71);
    wr(TA0_CTRL_ADDR, 8'h0f);
    noack(40);
    rd(PSW_ADDR, 8'h71, "psw_kept");
    rd(TA0_CTRL_ADDR, 8'h0f, "ctrl_kept");
    wr(TA0_CTRL_ADDR, 8'h0b);
    wr(PSW_ADDR, 8'h21);
    seq(6'h15, 3'h3, 18, 8'h21, 8'h30, wt);
    rd(TA0_CTRL_ADDR, 8'h03, "req_cleared");
  endtask

  task automatic t_soft();
    evt(8'h20);
    wr(TA0_CTRL_ADDR, 8'h03);
    rd(TA0_CTRL_ADDR, 8'h03, "sw_clear");
    @(posedge clk);
    reg_addr <= TA0_CTRL_ADDR;
    reg_wdata <= 8'h03;
    reg_wr <= 1'b1;
    src_evt <= 8'h20;
    @(posedge clk);
    reg_wr <= 1'b0;
    src_evt <= 8'h00;
    rd(TA0_CTRL_ADDR, 8'h0b, "req_not_lost");
    wr(TA0_CTRL_ADDR, 8'h03);
  endtask

  task automatic t_timing();
    logic [2:0] cmb[5] = '{3'b000, 3'b010, 3'b100, 3'b110, 3'b001};
    int ln[5] = '{18, 19, 19, 20, 20};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      {vec_odd, sp_odd, bus8} <= cmb[i];
      wr(PSW_ADDR, 8'h05);
      evt(8'h20);
      seq(6'h15, 3'h3, ln[i], 8'h05, 8'h30, wt);
    end
    @(posedge clk);
    {vec_odd, sp_odd, bus8} <= 3'b000;
  endtask

  // Debugger break, single step and a high software trap
  task automatic t_traps();
    logic [1:0] k[3] = '{2'h2, 2'h1, 2'h0};
    int ln[3] = '{20, 19, 18};
    logic [7:0] pa[3] = '{8'h20, 8'h20, 8'h24};
    for (int i = 0; i < 3; i++) begin
      wr(PSW_ADDR, 8'h27);
      @(posedge clk);
      cmd_kind <= k[i];
      cmd_num <= 6'h28;
      trap_cmd <= 1'b1;
      @(posedge clk);
      trap_cmd <= 1'b0;
      seq(6'h28, 3'h2, ln[i], 8'h27, pa[i], wt);
    end
  endtask

  task automatic t_susp();
    @(posedge clk);
    gap <= 8'h1e;
    instr_susp <= 1'b1;
    wr(PSW_ADDR, 8'h01);
    evt(8'h20);
    seq(6'h15, 3'h3, 18, 8'h01, 8'h30, wt);
    chk("susp_prompt", wt < 4, 1'b1);
    // Slow instruction with a request pending must raise the late flag
    @(posedge clk);
    instr_susp <= 1'b0;
    gap <= 8'hff;
    wr(PSW_ADDR, 8'h01);
    evt(8'h20);
    repeat (40) @(posedge clk);
    rd(STAT_ADDR, 8'h02, "late_flag");
    wr(PSW_ADDR, 8'h00);
    wr(TA0_CTRL_ADDR, 8'h03);
    wr(STAT_ADDR, 8'h00);
    rd(STAT_ADDR, 8'h00, "late_clear");
    @(posedge clk);
    gap <= 8'h04;
  endtask

  task automatic t_tie();
    wr(CTRL_BASE + 8'h02, 8'h04);
    wr(CTRL_BASE + 8'h06, 8'h04);
    wr(PSW_ADDR, 8'h01);
    evt(8'h44);
    seq(6'h12, 3'h4, 18, 8'h01, 8'h40, wt);
    rd(CTRL_BASE + 8'h06, 8'h0c, "loser_pending");
    // Software read of the info location takes the winner's request
    wr(PSW_ADDR, 8'h00);
    rd(INFO_LVL_ADDR, 8'h04, "info_lvl");
    rd(INFO_ADDR, 8'h16, "info_num");
    rd(CTRL_BASE + 8'h06, 8'h04, "info_cleared");
    evt(8'h40);
    wr(PSW_ADDR, 8'h01);
    seq(6'h16, 3'h4, 18, 8'h01, 8'h40, wt);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_gate();
    t_soft();
    t_timing();
    t_traps();
    t_susp();
    t_tie();
    end_of_test();
  end

  // Whole run is well under a thousand cycles; this leaves wide margin
  initial begin
    #200_000;
    fail_count++;
    end_of_test();
  end
endmodule // tb_maskable_interrupt_control

`default_nettype wire
